// file: verilog/boot_seq_consts.vh
// constants for the power-on boot and clock start sequencer
`ifndef BOOT_SEQ_CONSTS_VH
`define BOOT_SEQ_CONSTS_VH
`define BOOT_RESET_ADDR 32'h8000_0000
`define BOOT_CLK_PERIOD_NS 50
`define BOOT_SETTLE_NS 400
`define BOOT_SETTLE_CYC ((`BOOT_SETTLE_NS + `BOOT_CLK_PERIOD_NS - 1) / `BOOT_CLK_PERIOD_NS)
`define BOOT_SRC_RC 2'h0
`define BOOT_SRC_PLL0 2'h1
`define BOOT_SRC_PLL1 2'h2
`define BOOT_DIV_NONE 3'h0
`define BOOT_ST_HOLD 2'h0
`define BOOT_ST_SETTLE 2'h1
`define BOOT_ST_RUN 2'h2
`endif

// file: verilog/reset_release_sync.v
// two-stage reset release synchroniser
`timescale 1ns/1ns
`default_nettype none
module reset_release_sync (
	// clock and raw reset
	input wire clk_sys,
	input wire reset_n,
	// synchronised reset
	output wire sync_reset_n
);
	reg stage1_q;
	reg stage2_q;

	// assert at once, release only on a clean edge
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			stage1_q <= 1'b0;
			stage2_q <= 1'b0;
		end else begin
			stage1_q <= 1'b1;
			stage2_q <= stage1_q;
		end
	end

	assign sync_reset_n = stage2_q;
endmodule // reset_release_sync
`default_nettype wire

// file: verilog/power_on_boot_clock_start.v
// start-up sequencer: power-on hold, rc clock selection, boot fetch address
`timescale 1ns/1ns
`default_nettype none
`include "boot_seq_consts.vh"
module power_on_boot_clock_start #(
	parameter NUM_MODULES = 8,
	parameter SETTLE_CYC = `BOOT_SETTLE_CYC
) (
	// clock and reset
	input wire clk_sys,
	input wire reset_n,
	// power-on reset indication
	input wire power_good,
	// software clock requests, honoured only after boot
	input wire sw_cfg_we,
	input wire [1:0] sw_clk_src,
	input wire sw_pll0_en,
	input wire sw_pll1_en,
	input wire [NUM_MODULES-1:0] sw_clk_gate_en,
	input wire [NUM_MODULES*3-1:0] sw_clk_div,
	// system reset and cpu boot
	output wire sys_reset_n,
	output reg cpu_fetch_start,
	output reg [31:0] cpu_fetch_addr,
	// clock control outputs
	output reg [1:0] clk_src_sel,
	output reg pll0_enable,
	output reg pll1_enable,
	output reg [NUM_MODULES-1:0] module_clk_en,
	output reg [NUM_MODULES*3-1:0] module_clk_div,
	output reg boot_done
);
	// ----------------------------------------------------------------
	// local constants
	// ----------------------------------------------------------------
	// width of one module's divide code; code 0 means undivided
	localparam DIV_W = 3;
	localparam [DIV_W-1:0] DIV_NONE = `BOOT_DIV_NONE;
	// last settle count; the counter runs 0 .. SETTLE_LAST, then boot
	localparam integer SETTLE_LAST_INT = SETTLE_CYC - 1;
	localparam [15:0] SETTLE_LAST = SETTLE_LAST_INT[15:0];
	// boot values of the per-module clock fields: all clocked, none divided
	localparam [NUM_MODULES-1:0] EN_BOOT = {NUM_MODULES{1'b1}};
	localparam [NUM_MODULES*DIV_W-1:0] DIV_BOOT = {NUM_MODULES{`BOOT_DIV_NONE}};
	// fixed first fetch address, the base of internal flash
	localparam [31:0] RESET_ADDR = `BOOT_RESET_ADDR;

	// ----------------------------------------------------------------
	// reset release
	// ----------------------------------------------------------------
	wire sync_reset_n;
	reg [1:0] state_q;
	reg [1:0] state_d;
	reg [15:0] settle_q;
	reg [15:0] settle_d;

	// hardware reset released on a clean clock edge
	reset_release_sync u_rst_sync (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.sync_reset_n(sync_reset_n)
	);

	// system held while power unstable or still settling
	assign sys_reset_n = (state_q == `BOOT_ST_RUN);

	// ----------------------------------------------------------------
	// power sequencing state machine
	// ----------------------------------------------------------------
	// any drop of power_good returns to hold, a brown-out restarts boot
	always @* begin
		state_d = state_q;
		settle_d = settle_q;
		case (state_q)
			`BOOT_ST_HOLD: begin
				settle_d = 16'h0000;
				if (power_good)
					state_d = `BOOT_ST_SETTLE;
			end
			`BOOT_ST_SETTLE: begin
				if (!power_good)
					state_d = `BOOT_ST_HOLD;
				else if (settle_q >= SETTLE_LAST)
					state_d = `BOOT_ST_RUN;
				else
					settle_d = settle_q + 16'h0001;
			end
			`BOOT_ST_RUN: begin
				if (!power_good)
					state_d = `BOOT_ST_HOLD;
			end
			default: state_d = `BOOT_ST_HOLD;
		endcase
	end

	always @(posedge clk_sys or negedge sync_reset_n) begin
		if (!sync_reset_n) begin
			state_q <= `BOOT_ST_HOLD;
			settle_q <= 16'h0000;
		end else begin
			state_q <= state_d;
			settle_q <= settle_d;
		end
	end

	// ----------------------------------------------------------------
	// cpu boot fetch
	// ----------------------------------------------------------------
	wire enter_run;

	// run is entered on exactly one edge per boot, brown-out restarts included
	assign enter_run = (state_d == `BOOT_ST_RUN) && (state_q != `BOOT_ST_RUN);

	// one-cycle start pulse in the first cycle out of reset; the address is
	// constant but kept in a flop so the cpu sees a clean registered value
	always @(posedge clk_sys or negedge sync_reset_n) begin
		if (!sync_reset_n) begin
			cpu_fetch_start <= 1'b0;
			cpu_fetch_addr <= RESET_ADDR;
			boot_done <= 1'b0;
		end else begin
			cpu_fetch_start <= enter_run;
			cpu_fetch_addr <= RESET_ADDR;
			boot_done <= (state_d == `BOOT_ST_RUN);
		end
	end

	// ----------------------------------------------------------------
	// software write decode
	// ----------------------------------------------------------------
	// the port only counts once the system runs, so a write during the
	// start-up window cannot race the boot defaults
	wire boot_run;
	wire cfg_accept;
	wire src_pll0_ok;
	wire src_pll1_ok;
	wire [1:0] src_req;

	assign boot_run = (state_q == `BOOT_ST_RUN);
	assign cfg_accept = sw_cfg_we && boot_run;
	// a pll source is only taken if the same write enables that pll,
	// so the system never runs from a stopped clock
	assign src_pll0_ok = (sw_clk_src == `BOOT_SRC_PLL0) && sw_pll0_en;
	assign src_pll1_ok = (sw_clk_src == `BOOT_SRC_PLL1) && sw_pll1_en;
	assign src_req = (src_pll0_ok || src_pll1_ok) ? sw_clk_src : `BOOT_SRC_RC;

	// ----------------------------------------------------------------
	// clock source and pll enables
	// ----------------------------------------------------------------
	reg [1:0] clk_src_d;
	reg pll0_d;
	reg pll1_d;

	// boot defaults hold outside run; a write replaces all fields at once
	always @* begin
		clk_src_d = clk_src_sel;
		pll0_d = pll0_enable;
		pll1_d = pll1_enable;
		if (!boot_run) begin
			clk_src_d = `BOOT_SRC_RC;
			pll0_d = 1'b0;
			pll1_d = 1'b0;
		end else if (cfg_accept) begin
			clk_src_d = src_req;
			pll0_d = sw_pll0_en;
			pll1_d = sw_pll1_en;
		end
	end

	// registered so the clock switch sees a glitch-free select
	always @(posedge clk_sys or negedge sync_reset_n) begin
		if (!sync_reset_n) begin
			clk_src_sel <= `BOOT_SRC_RC;
			pll0_enable <= 1'b0;
			pll1_enable <= 1'b0;
		end else begin
			clk_src_sel <= clk_src_d;
			pll0_enable <= pll0_d;
			pll1_enable <= pll1_d;
		end
	end

	// ----------------------------------------------------------------
	// per-module clock gate and divider
	// ----------------------------------------------------------------
	wire [NUM_MODULES-1:0] clk_en_d;
	wire [NUM_MODULES*DIV_W-1:0] clk_div_d;
	genvar m;

	// one slice per module: boot forces clocked and undivided, a write
	// hands each module its own gate bit and divide code; no write
	// means the slice keeps its value
	generate
		for (m = 0; m < NUM_MODULES; m = m + 1) begin : g_module_clk
			assign clk_en_d[m] = !boot_run ? 1'b1 :
				(cfg_accept ? sw_clk_gate_en[m] : module_clk_en[m]);
			assign clk_div_d[m*DIV_W +: DIV_W] = !boot_run ? DIV_NONE :
				(cfg_accept ? sw_clk_div[m*DIV_W +: DIV_W] :
				module_clk_div[m*DIV_W +: DIV_W]);
		end
	endgenerate

	// per-module clock fields; a reset always restores the boot values
	always @(posedge clk_sys or negedge sync_reset_n) begin
		if (!sync_reset_n) begin
			module_clk_en <= EN_BOOT;
			module_clk_div <= DIV_BOOT;
		end else begin
			module_clk_en <= clk_en_d;
			module_clk_div <= clk_div_d;
		end
	end
endmodule // power_on_boot_clock_start
`default_nettype wire

// file: testbench/boot_seq_props.sv
// checker for the boot sequencer outputs
`timescale 1ns/1ns
`default_nettype none
`include "boot_seq_consts.vh"
module boot_seq_props #(parameter NUM_MODULES = 8) (
	// clock, reset, inputs
	input wire clk_sys, input wire reset_n, input wire power_good,
	input wire sw_cfg_we, input wire [NUM_MODULES-1:0] sw_clk_gate_en,
	// outputs watched
	input wire sys_reset_n, input wire cpu_fetch_start, input wire [31:0] cpu_fetch_addr,
	input wire [1:0] clk_src_sel, input wire pll0_enable, input wire pll1_enable,
	input wire [NUM_MODULES-1:0] module_clk_en, input wire [NUM_MODULES*3-1:0] module_clk_div,
	input wire boot_done
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	// start-up state is judged at the edge reset lifts
	a_hold_no_power: assert property (!power_good |=> !sys_reset_n) else $error("early release");
	a_rc_at_start: assert property ($rose(sys_reset_n) |-> clk_src_sel == `BOOT_SRC_RC) else $error("src");
	a_plls_off: assert property ($rose(sys_reset_n) |-> !pll0_enable && !pll1_enable) else $error("pll");
	a_clocks_full: assert property ($rose(sys_reset_n) |-> &module_clk_en && !(|module_clk_div))
		else $error("clk en or div");
	a_fetch_once: assert property ($rose(sys_reset_n) |-> cpu_fetch_start ##1 !cpu_fetch_start)
		else $error("fetch pulse");
	a_fetch_addr: assert property (cpu_fetch_addr == `BOOT_RESET_ADDR) else $error("fetch addr");
	a_fetch_released: assert property (cpu_fetch_start |-> sys_reset_n && boot_done) else $error("fetch");
	a_sw_gate_taken: assert property (sw_cfg_we && sys_reset_n && power_good |=>
		module_clk_en == $past(sw_clk_gate_en)) else $error("gate write");
endmodule // boot_seq_props
bind power_on_boot_clock_start boot_seq_props #(.NUM_MODULES(NUM_MODULES)) boot_seq_props_inst (.*);
`default_nettype wire

// file: testbench/cpu_fetch_model.sv
// cpu side model: counts boot fetches, keeps the fetch address
`timescale 1ns/1ns
`default_nettype none
module cpu_fetch_model (
	// boot outputs of the sequencer
	input wire clk_sys, input wire sys_reset_n, input wire cpu_fetch_start,
	input wire [31:0] cpu_fetch_addr,
	// what the cpu saw
	output logic [7:0] fetch_cnt_q, output logic [31:0] fetch_addr_q
);
	// the core starts with nothing fetched
	initial begin
		fetch_cnt_q = 8'h00;
		fetch_addr_q = 32'h0;
	end
	// a start while still in reset would be lost by a real core, so it is not counted
	always @(posedge clk_sys) begin
		if (cpu_fetch_start && sys_reset_n) begin
			fetch_cnt_q <= fetch_cnt_q + 8'h01;
			fetch_addr_q <= cpu_fetch_addr;
		end
	end
endmodule // cpu_fetch_model
`default_nettype wire

// file: testbench/test_power_on_boot_clock_start.sv
// testbench for the power-on boot and clock start sequencer
`timescale 1ns/1ns
`default_nettype none
`include "boot_seq_consts.vh"
module test_power_on_boot_clock_start;
	localparam int SETTLE = 2; // short settle keeps the run brief
	logic clk_sys = 1'b0, reset_n = 1'b0, power_good = 1'b0, sw_cfg_we = 1'b0;
	logic sw_pll0_en = 1'b0, sw_pll1_en = 1'b0;
	logic [1:0] sw_clk_src = 2'h0;
	logic [7:0] sw_clk_gate_en = 8'h00;
	logic [23:0] sw_clk_div = 24'h000000;
	wire sys_reset_n, cpu_fetch_start, pll0_enable, pll1_enable, boot_done;
	wire [1:0] clk_src_sel;
	wire [7:0] module_clk_en, fetch_cnt_q;
	wire [23:0] module_clk_div;
	wire [31:0] cpu_fetch_addr, fetch_addr_q;
	int mismatches = 0, checked = 0;
	always #25 clk_sys = ~clk_sys;
	power_on_boot_clock_start #(.NUM_MODULES(8), .SETTLE_CYC(SETTLE)) power_on_boot_clock_start_inst (
		.clk_sys(clk_sys), .reset_n(reset_n), .power_good(power_good), .sw_cfg_we(sw_cfg_we),
		.sw_clk_src(sw_clk_src), .sw_pll0_en(sw_pll0_en), .sw_pll1_en(sw_pll1_en),
		.sw_clk_gate_en(sw_clk_gate_en), .sw_clk_div(sw_clk_div), .sys_reset_n(sys_reset_n),
		.cpu_fetch_start(cpu_fetch_start), .cpu_fetch_addr(cpu_fetch_addr), .clk_src_sel(clk_src_sel),
		.pll0_enable(pll0_enable), .pll1_enable(pll1_enable), .module_clk_en(module_clk_en),
		.module_clk_div(module_clk_div), .boot_done(boot_done));
	cpu_fetch_model cpu_fetch_model_inst (.clk_sys(clk_sys), .sys_reset_n(sys_reset_n),
		.cpu_fetch_start(cpu_fetch_start), .cpu_fetch_addr(cpu_fetch_addr),
		.fetch_cnt_q(fetch_cnt_q), .fetch_addr_q(fetch_addr_q));
	task chk(string name, logic [31:0] exp, logic [31:0] got);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask
	task end_of_test;
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	// one strobe cycle, then one cycle for the outputs to land
	task sw_write(logic [1:0] src, logic p0, logic p1, logic [7:0] gate, logic [23:0] div);
		@(negedge clk_sys);
		{sw_cfg_we, sw_clk_src, sw_pll0_en, sw_pll1_en, sw_clk_gate_en, sw_clk_div} = {1'b1, src, p0, p1, gate, div};
		@(negedge clk_sys);
		sw_cfg_we = 1'b0;
		@(negedge clk_sys);
	endtask
	task start_state;
		chk("src_pll", 32'h0, {clk_src_sel, pll0_enable, pll1_enable});
		chk("en_div", {8'hFF, 24'h0}, {module_clk_en, module_clk_div});
	endtask
	// a write while held in reset must be ignored
	task t_hold;
		sw_write(`BOOT_SRC_PLL0, 1'b1, 1'b0, 8'h00, 24'hFFFFFF);
		repeat (20) @(negedge clk_sys);
		chk("hold_reset", 32'h0, {sys_reset_n, boot_done});
		start_state();
		$display("t_hold done");
	endtask
	task t_boot(logic [7:0] n);
		power_good = 1'b1;
		repeat (SETTLE + 6) if (!sys_reset_n) @(negedge clk_sys);
		chk("released", 32'h3, {sys_reset_n, boot_done});
		start_state();
		chk("fetch_start", 32'h1, cpu_fetch_start);
		@(negedge clk_sys);
		chk("fetch_end", 32'h0, cpu_fetch_start);
		chk("fetch_seen", {n, `BOOT_RESET_ADDR}, {fetch_cnt_q, fetch_addr_q});
		$display("t_boot done");
	endtask
	task t_sw;
		sw_write(`BOOT_SRC_PLL1, 1'b0, 1'b1, 8'h0F, 24'h123456);
		chk("pll1", {`BOOT_SRC_PLL1, 2'h1}, {clk_src_sel, pll0_enable, pll1_enable});
		chk("gate_div", {8'h0F, 24'h123456}, {module_clk_en, module_clk_div});
		sw_write(`BOOT_SRC_PLL0, 1'b0, 1'b0, 8'hFF, 24'h0);
		chk("fallback", {`BOOT_SRC_RC, 2'h0}, {clk_src_sel, pll0_enable, pll1_enable});
		$display("t_sw done");
	endtask
	// power loss in mid-run restores the start-up state
	task t_drop;
		sw_write(`BOOT_SRC_PLL0, 1'b1, 1'b1, 8'h01, 24'h000007);
		power_good = 1'b0;
		repeat (3) @(negedge clk_sys);
		chk("drop_reset", 32'h0, sys_reset_n);
		start_state();
		t_boot(8'h02);
		$display("t_drop done");
	endtask
	initial begin
		repeat (6) @(negedge clk_sys);
		reset_n = 1'b1;
		repeat (2) @(negedge clk_sys);
		t_hold();
		t_boot(8'h01);
		t_sw();
		t_drop();
		end_of_test();
	end
	// the tests need some 50 cycles; give them well over twice that
	initial begin
		#20000;
		mismatches++;
		end_of_test();
	end
endmodule // test_power_on_boot_clock_start
`default_nettype wire
